/* include/ciox_regs.vh */
// Constants for the camera control expander block
`ifndef CIOX_REGS_VH
`define CIOX_REGS_VH

// Bus addresses on the control bus
`define CIOX_I2C_ADDR_EXP 7'h20
`define CIOX_I2C_ADDR_SENSOR 7'h1A
`define CIOX_I2C_ADDR_MEM_A 7'h50
`define CIOX_I2C_ADDR_MEM_B 7'h57
`define CIOX_I2C_BITS 4'h8

// Expander line positions
`define CIOX_P_SUPPLY 0
`define CIOX_P_RESET_N 1
`define CIOX_P_LEVEL 2
`define CIOX_P_DRIVE 3
`define CIOX_P_SOURCE 4
`define CIOX_P_TRIG_POL 5
`define CIOX_P_TRIG_SRC 6
`define CIOX_P_SPARE 7
`define CIOX_PORT_RESET 8'h00

// Register word offsets (byte address bits 3:2)
`define CIOX_REG_CTRL 2'h0
`define CIOX_REG_STATUS 2'h1
`define CIOX_REG_IRQ_STAT 2'h2
`define CIOX_REG_IRQ_MASK 2'h3

// Control fields
`define CIOX_CTRL_EN 0
`define CIOX_CTRL_RESET 1'h1

// Status fields
`define CIOX_ST_BUSY 8
`define CIOX_ST_TRIG 9
`define CIOX_ST_OVC 10

// Interrupt bits
`define CIOX_IRQ_W 3
`define CIOX_IRQ_WRITE 0
`define CIOX_IRQ_OVC 1
`define CIOX_IRQ_TRIG 2
`define CIOX_IRQ_MASK_RESET 3'h0

`endif

/* hdl/ciox_sync.v */
// Two-flop synchroniser bank for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none

module ciox_sync #(
  parameter W = 1
) (
  input wire ref_clk_in,
  input wire arst_n_in,
  input wire ce_in,
  input wire [W-1:0] d_in,
  output wire [W-1:0] q_out
);

  genvar i;

  // One two-stage chain per bit
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      always @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else if (ce_in) begin
          s1_q <= d_in[i];
          s2_q <= s1_q;
        end
      end
      assign q_out[i] = s2_q;
    end
  endgenerate

endmodule

`default_nettype wire

/* hdl/ciox_top.v */
// Camera control expander: bus target, line routing, register slave
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ciox_regs.vh"

module ciox_top (
  input wire ref_clk_in,
  input wire arst_n_in,
  input wire ce_in,
  // Avalon-MM register slave
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  output wire irq_out,
  // Control bus from the host side
  input wire i2c_scl_in,
  input wire i2c_sda_in,
  output wire i2c_sda_out,
  output reg i2c_sda_oe_out,
  // Sensor side
  output reg sensor_supply_enable_out,
  output reg sensor_reset_n_out,
  input wire sensor_strobe_in,
  output reg sensor_trigger_out,
  input wire ser_clk_in,
  output wire sensor_clk_out,
  // Serializer lines
  output reg ser_strobe_out,
  input wire link_external_trigger_in,
  // Connector and indicators
  input wire conn_trigger_in,
  input wire overcurrent_sense_in,
  output reg user_output_pin_out,
  output reg user_output_pin_oe_out,
  output reg green_indicator_out,
  output reg red_overcurrent_indicator_out
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ACK_A = 3'h2;
  localparam ST_WRITE = 3'h3;
  localparam ST_ACK_W = 3'h4;
  localparam ST_READ = 3'h5;
  localparam ST_RACK = 3'h6;

  wire [5:0] sync_q;
  wire scl_s;
  wire sda_s;
  wire strobe_s;
  wire link_trig_s;
  wire conn_trig_s;
  wire ovc_s;
  reg scl_prev_q;
  reg sda_prev_q;
  wire scl_rise;
  wire scl_fall;
  wire bus_start;
  wire bus_stop;

  reg [2:0] state_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg rw_q;
  reg mack_q;
  reg wr_stb_q;
  reg [7:0] port_q;

  reg ctrl_en_q;
  reg [2:0] irq_stat_q;
  reg [2:0] irq_mask_q;
  reg ack_q;
  wire [2:0] irq_evt;
  reg ovc_prev_q;
  reg trig_prev_q;
  wire user_value;
  wire conn_trig_pol;
  wire trig_sel;
  wire bus_req;
  wire [1:0] reg_idx;
  reg [31:0] rd_mux;

  // Pin and link inputs through two flops each
  ciox_sync #(
    .W(6)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .ce_in(ce_in),
    .d_in({overcurrent_sense_in, conn_trigger_in, link_external_trigger_in,
           sensor_strobe_in, i2c_sda_in, i2c_scl_in}),
    .q_out(sync_q)
  );

  assign scl_s = sync_q[0];
  assign sda_s = sync_q[1];
  assign strobe_s = sync_q[2];
  assign link_trig_s = sync_q[3];
  assign conn_trig_s = sync_q[4];
  assign ovc_s = sync_q[5];

  // Previous bus levels for edge detection
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else if (ce_in) begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // Bus edges and start/stop conditions
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign bus_stop = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // Open-drain data line: only ever pulled low
  assign i2c_sda_out = 1'b0;

  // Bus target state machine
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
      wr_stb_q <= 1'b0;
      i2c_sda_oe_out <= 1'b0;
      port_q <= `CIOX_PORT_RESET;
    end else if (ce_in) begin
      wr_stb_q <= 1'b0;
      if (bus_stop || !ctrl_en_q) begin
        state_q <= ST_IDLE;
        i2c_sda_oe_out <= 1'b0;
      end else if (bus_start) begin
        state_q <= ST_ADDR;
        cnt_q <= 4'h0;
        i2c_sda_oe_out <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            i2c_sda_oe_out <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == `CIOX_I2C_BITS) begin
              // Only the expander address is claimed; other targets pass by
              if (sh_q[7:1] == `CIOX_I2C_ADDR_EXP) begin
                rw_q <= sh_q[0];
                i2c_sda_oe_out <= 1'b1;
                state_q <= ST_ACK_A;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_ACK_A: begin
            if (scl_fall) begin
              cnt_q <= 4'h0;
              if (rw_q) begin
                sh_q <= port_q;
                i2c_sda_oe_out <= ~port_q[7];
                state_q <= ST_READ;
              end else begin
                i2c_sda_oe_out <= 1'b0;
                state_q <= ST_WRITE;
              end
            end
          end
          ST_WRITE: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == `CIOX_I2C_BITS) begin
              // Each data byte lands on the expander lines
              port_q <= sh_q;
              wr_stb_q <= 1'b1;
              i2c_sda_oe_out <= 1'b1;
              state_q <= ST_ACK_W;
            end
          end
          ST_ACK_W: begin
            if (scl_fall) begin
              cnt_q <= 4'h0;
              i2c_sda_oe_out <= 1'b0;
              state_q <= ST_WRITE;
            end
          end
          ST_READ: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (cnt_q == `CIOX_I2C_BITS) begin
                i2c_sda_oe_out <= 1'b0;
                state_q <= ST_RACK;
              end else begin
                sh_q <= {sh_q[6:0], 1'b0};
                i2c_sda_oe_out <= ~sh_q[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              mack_q <= ~sda_s;
            end else if (scl_fall) begin
              cnt_q <= 4'h0;
              if (mack_q) begin
                sh_q <= port_q;
                i2c_sda_oe_out <= ~port_q[7];
                state_q <= ST_READ;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
            i2c_sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // Clock to the sensor is the serializer clock, untouched
  assign sensor_clk_out = ser_clk_in;

  // Line decode terms
  assign user_value = port_q[`CIOX_P_SOURCE] ? port_q[`CIOX_P_LEVEL] : strobe_s;
  assign conn_trig_pol = conn_trig_s ^ port_q[`CIOX_P_TRIG_POL];
  assign trig_sel = port_q[`CIOX_P_TRIG_SRC] ? conn_trig_pol : link_trig_s;

  // Registered camera control outputs; the spare line feeds nothing
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sensor_supply_enable_out <= 1'b0;
      sensor_reset_n_out <= 1'b0;
      sensor_trigger_out <= 1'b0;
      ser_strobe_out <= 1'b0;
      user_output_pin_out <= 1'b0;
      user_output_pin_oe_out <= 1'b0;
      green_indicator_out <= 1'b0;
      red_overcurrent_indicator_out <= 1'b0;
    end else if (ce_in) begin
      sensor_supply_enable_out <= port_q[`CIOX_P_SUPPLY];
      sensor_reset_n_out <= port_q[`CIOX_P_RESET_N];
      sensor_trigger_out <= trig_sel;
      ser_strobe_out <= strobe_s;
      if (port_q[`CIOX_P_DRIVE]) begin
        // Push-pull: drive both levels
        user_output_pin_out <= user_value;
        user_output_pin_oe_out <= 1'b1;
      end else begin
        // Open-drain: pull low for 0, release for 1
        user_output_pin_out <= 1'b0;
        user_output_pin_oe_out <= ~user_value;
      end
      green_indicator_out <= ~port_q[`CIOX_P_SOURCE] & port_q[`CIOX_P_LEVEL];
      red_overcurrent_indicator_out <= ovc_s & port_q[`CIOX_P_DRIVE];
    end
  end

  // Event history for edge detection
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ovc_prev_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end else if (ce_in) begin
      ovc_prev_q <= red_overcurrent_indicator_out;
      trig_prev_q <= sensor_trigger_out;
    end
  end

  // Events: expander write, red overcurrent indicator onset (needs drive bit), trigger rising edge
  assign irq_evt[`CIOX_IRQ_WRITE] = wr_stb_q;
  assign irq_evt[`CIOX_IRQ_OVC] = red_overcurrent_indicator_out & ~ovc_prev_q;
  assign irq_evt[`CIOX_IRQ_TRIG] = sensor_trigger_out & ~trig_prev_q;

  // Bus handshake: one wait cycle, then answer
  assign bus_req = (avs_read_in | avs_write_in) & ~ack_q;
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
  assign reg_idx = avs_address_in[3:2];

  // Read data selection, unused bits read zero
  always @* begin
    rd_mux = 32'h0000_0000;
    case (reg_idx)
      `CIOX_REG_CTRL: rd_mux[`CIOX_CTRL_EN] = ctrl_en_q;
      `CIOX_REG_STATUS: begin
        rd_mux[7:0] = port_q;
        rd_mux[`CIOX_ST_BUSY] = (state_q != ST_IDLE);
        rd_mux[`CIOX_ST_TRIG] = conn_trig_pol;
        rd_mux[`CIOX_ST_OVC] = red_overcurrent_indicator_out;
      end
      `CIOX_REG_IRQ_STAT: rd_mux[`CIOX_IRQ_W-1:0] = irq_stat_q;
      `CIOX_REG_IRQ_MASK: rd_mux[`CIOX_IRQ_W-1:0] = irq_mask_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Register slave and sticky interrupt status; writes land when waitrequest is low
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_q <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
      ctrl_en_q <= `CIOX_CTRL_RESET;
      irq_stat_q <= `CIOX_IRQ_MASK_RESET;
      irq_mask_q <= `CIOX_IRQ_MASK_RESET;
    end else if (ce_in) begin
      ack_q <= bus_req;
      if (bus_req && avs_read_in) begin
        avs_readdata_out <= rd_mux;
      end
      if (ack_q && avs_write_in && reg_idx == `CIOX_REG_CTRL) begin
        ctrl_en_q <= avs_writedata_in[`CIOX_CTRL_EN];
      end
      if (ack_q && avs_write_in && reg_idx == `CIOX_REG_IRQ_MASK) begin
        irq_mask_q <= avs_writedata_in[`CIOX_IRQ_W-1:0];
      end
      // New events win over a write-one clear in the same cycle
      if (ack_q && avs_write_in && reg_idx == `CIOX_REG_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~avs_writedata_in[`CIOX_IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat_q <= irq_stat_q | irq_evt;
      end
    end
  end

  // Level interrupt while any unmasked status bit is set
  assign irq_out = |(irq_stat_q & irq_mask_q);

endmodule

`default_nettype wire

/* tb/ciox_top_properties.sv */
// Port checks for the camera control expander
`timescale 1ns/1ps
`default_nettype none
module ciox_top_properties (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic i2c_scl_in,
  input wire logic i2c_sda_oe_out,
  input wire logic sensor_strobe_in,
  input wire logic ser_strobe_out,
  input wire logic ser_clk_in,
  input wire logic sensor_clk_out,
  input wire logic overcurrent_sense_in,
  input wire logic user_output_pin_out,
  input wire logic user_output_pin_oe_out,
  input wire logic green_indicator_out,
  input wire logic red_overcurrent_indicator_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  // Feed-through, routing and latency checks
  chk_sensor_clk: assert property (sensor_clk_out == ser_clk_in)
    else $error("sensor clock differs");
  chk_red_drive: assert property (red_overcurrent_indicator_out |-> user_output_pin_oe_out)
    else $error("red lit without driver");
  chk_red_cause: assert property ($rose(red_overcurrent_indicator_out) |->
    $past(overcurrent_sense_in, 3))
    else $error("red rose without overcurrent");
  chk_strobe_copy: assert property (ser_strobe_out == $past(sensor_strobe_in, 3))
    else $error("strobe copy wrong");
  chk_wait_once: assert property ($rose(avs_read_in || avs_write_in) |->
    avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("wait timing wrong");
  chk_ack_edge: assert property ($changed(i2c_sda_oe_out) |-> !$past(i2c_scl_in, 2))
    else $error("data drive moved with clock high");
  chk_green_route: assert property (green_indicator_out |-> (user_output_pin_oe_out ?
    user_output_pin_out == ser_strobe_out : ser_strobe_out))
    else $error("green lit but pin not on strobe");
  chk_open_drain: assert property (user_output_pin_out |-> user_output_pin_oe_out)
    else $error("pin high while released");
  chk_read_hold: assert property (!avs_read_in |=> $stable(avs_readdata_out))
    else $error("read data moved");
  // Main scenarios reached
  cover property ($rose(red_overcurrent_indicator_out));
  cover property ($rose(i2c_sda_oe_out));
  cover property ($rose(green_indicator_out));
endmodule
bind ciox_top ciox_top_properties ciox_top_properties_inst (.ref_clk_in, .arst_n_in,
  .avs_read_in, .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .i2c_scl_in,
  .i2c_sda_oe_out, .sensor_strobe_in, .ser_strobe_out, .ser_clk_in, .sensor_clk_out,
  .overcurrent_sense_in, .user_output_pin_out, .user_output_pin_oe_out,
  .green_indicator_out, .red_overcurrent_indicator_out);
`default_nettype wire

/* tb/ciox_host_model.sv */
// Host control bus master model, open drain with pull-up
`timescale 1ns/1ps
`default_nettype none
module ciox_host_model (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic pull_out
);
  // Idle bus: clock stands high, data released
  initial begin
    scl_out = 1'b1;
    pull_out = 1'b0;
  end
  // Half of the 80 ns bus period
  task automatic half;
    repeat (8) @(posedge clk_in);
  endtask
  // One bit; data moves only with clock low, sampled while high
  task automatic slot(input logic b, output logic seen);
    pull_out <= ~b;
    repeat (6) @(posedge clk_in);
    scl_out <= 1'b1;
    half;
    seen = sda_in;
    scl_out <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
  // START, address byte, one data byte, STOP
  task automatic frame(input logic [6:0] addr, input logic rd, input logic [7:0] wd,
    output logic ack, output logic [7:0] rdata);
    logic s;
    logic [7:0] a;
    a = {addr, rd};
    pull_out <= 1'b1;
    half;
    scl_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    for (int i = 7; i >= 0; i--) slot(a[i], s);
    slot(1'b1, s);
    ack = ~s;
    for (int i = 7; i >= 0; i--) begin
      slot(rd | wd[i], s);
      rdata[i] = s;
    end
    slot(1'b1, s); // Read ends with not-acknowledge
    ack = ack & (rd | ~s);
    pull_out <= 1'b1;
    half;
    scl_out <= 1'b1;
    half;
    pull_out <= 1'b0;
    half;
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the camera control expander
`timescale 1ns/1ps
`default_nettype none
`include "ciox_regs.vh"
module testbench;
  logic ref_clk_in, arst_n_in, avs_read_in, avs_write_in, sensor_strobe_in, ser_clk_in;
  logic link_external_trigger_in, conn_trigger_in, overcurrent_sense_in, host_pull, ack;
  logic ce_in = 1'b1;
  logic [3:0] avs_address_in;
  logic [31:0] avs_writedata_in, q, r;
  logic [31:0] seed = 32'h0000A8F4;
  logic [7:0] d, p, rb;
  logic [7:0] corners [4] = '{8'h1F, 8'h13, 8'h2B, 8'hC7};
  logic [6:0] others [3] = '{`CIOX_I2C_ADDR_SENSOR, `CIOX_I2C_ADDR_MEM_A, `CIOX_I2C_ADDR_MEM_B};
  wire [31:0] avs_readdata_out;
  wire avs_waitrequest_out, irq_out, i2c_scl_in, i2c_sda_in, i2c_sda_out, i2c_sda_oe_out;
  wire sensor_supply_enable_out, sensor_reset_n_out, sensor_trigger_out, sensor_clk_out;
  wire ser_strobe_out, user_output_pin_out, user_output_pin_oe_out;
  wire green_indicator_out, red_overcurrent_indicator_out;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  ciox_top ciox_top_inst (.ref_clk_in, .arst_n_in, .ce_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .irq_out,
    .i2c_scl_in, .i2c_sda_in, .i2c_sda_out, .i2c_sda_oe_out, .sensor_supply_enable_out,
    .sensor_reset_n_out, .sensor_strobe_in, .sensor_trigger_out, .ser_clk_in,
    .sensor_clk_out, .ser_strobe_out, .link_external_trigger_in, .conn_trigger_in,
    .overcurrent_sense_in, .user_output_pin_out, .user_output_pin_oe_out,
    .green_indicator_out, .red_overcurrent_indicator_out);
  ciox_host_model ciox_host_model_inst (.clk_in(ref_clk_in), .sda_in(i2c_sda_in),
    .scl_out(i2c_scl_in), .pull_out(host_pull));
  // Wired-AND data line with pull-up
  assign i2c_sda_in = ~(host_pull | (i2c_sda_oe_out & ~i2c_sda_out));
  // Clock and hang guard
  always #2.5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim;
    end
  end
  function automatic logic [31:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected {pin, pin enable, green, red, trigger}; r = {ovc, conn, link, strobe}
  function automatic logic [4:0] exp_pins(input logic [7:0] p, input logic [3:0] r);
    logic v;
    v = p[4] ? p[2] : r[0];
    return {p[3] & v, p[3] | ~v, ~p[4] & p[2], r[3] & p[3], p[6] ? r[2] ^ p[5] : r[1]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Routed pin outputs against the rules for port byte pv and levels lv
  task automatic pins(input logic [7:0] pv, input logic [3:0] lv);
    logic [4:0] e;
    e = exp_pins(pv, lv);
    check({user_output_pin_out, user_output_pin_oe_out}, e[4:3]);
    check(green_indicator_out, e[2]);
    check(red_overcurrent_indicator_out, e[1]);
    check(sensor_trigger_out, e[0]);
    check({sensor_reset_n_out, sensor_supply_enable_out}, pv[1:0]);
  endtask
  // One register cycle, held until wait drops; only the bench timeout ends a hang
  task automatic av(input logic w, input logic [1:0] off, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge ref_clk_in);
    avs_read_in <= ~w;
    avs_write_in <= w;
    avs_address_in <= {off, 2'h0};
    avs_writedata_in <= wd;
    do begin
      @(posedge ref_clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic end_sim;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    ref_clk_in = 1'b0;
    arst_n_in = 1'b0;
    {avs_read_in, avs_write_in, sensor_strobe_in, ser_clk_in} = 4'h0;
    {link_external_trigger_in, conn_trigger_in, overcurrent_sense_in} = 3'h0;
    avs_address_in = 4'h0;
    avs_writedata_in = 32'h0;
    repeat (16) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    check(sensor_supply_enable_out, 0);
    check(sensor_reset_n_out, 0);
    av(0, `CIOX_REG_CTRL, 0, q);
    check(q, 1);
    d = rnd();
    d[1] = d[1] & d[0];
    ciox_host_model_inst.frame(`CIOX_I2C_ADDR_EXP, 0, d, ack, rb);
    check(ack, 1);
    check(sensor_supply_enable_out, d[0]);
    check(sensor_reset_n_out, d[1]);
    check(irq_out, 0);
    av(0, `CIOX_REG_IRQ_STAT, 0, q);
    check(q, 32'h1 | ((d[6] & d[5]) << 2));
    av(1, `CIOX_REG_IRQ_MASK, 32'h1, q);
    @(posedge ref_clk_in);
    check(irq_out, 1);
    av(1, `CIOX_REG_IRQ_STAT, 32'h7, q);
    @(posedge ref_clk_in);
    check(irq_out, 0);
    ciox_host_model_inst.frame(`CIOX_I2C_ADDR_EXP, 1, 0, ack, rb);
    check({ack, rb}, {1'b1, d});
    foreach (others[i]) begin
      ciox_host_model_inst.frame(others[i], 0, ~d, ack, rb);
      check(ack, 0);
    end
    av(0, `CIOX_REG_STATUS, 0, q);
    check(q[7:0], d);
    // Line routing over corner and random port values and pin levels
    for (int k = 0; k < 14; k++) begin
      p = (k < 4) ? corners[k] : rnd();
      p[1] = p[1] & p[0];
      ciox_host_model_inst.frame(`CIOX_I2C_ADDR_EXP, 0, p, ack, rb);
      r = rnd();
      {ser_clk_in, overcurrent_sense_in, conn_trigger_in} <= r[4:2];
      {link_external_trigger_in, sensor_strobe_in} <= r[1:0];
      repeat (6) @(posedge ref_clk_in);
      pins(p, r[3:0]);
      check(ser_strobe_out, r[0]);
      check(sensor_clk_out, r[4]);
    end
    // Clock enable low freezes the routed pin outputs despite new pin levels
    ce_in <= 1'b0;
    {overcurrent_sense_in, conn_trigger_in, link_external_trigger_in} <= ~r[3:1];
    repeat (6) @(posedge ref_clk_in);
    pins(p, r[3:0]);
    ce_in <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    pins(p, {~r[3:1], r[0]});
    end_sim;
  end
endmodule
`default_nettype wire
